/* File: hw/olc_flag_latch.sv */
// Purpose: Sticky per-channel change flags, cleared by a status read
// Assumes: One clock, synchronous status inputs
// Notes:   A set in the clearing cycle wins
`timescale 1ns/1ps
module olc_flag_latch #(
    parameter int NCH = 8
) (
    input  wire logic           sys_clk,
    input  wire logic           rst_n,
    input  wire logic           soft_rst,
    input  wire logic [NCH-1:0] set_vec,
    input  wire logic           clr,
    output logic      [NCH-1:0] flag
);
    logic [NCH-1:0] flag_q;
    logic [NCH-1:0] flag_d;

    always_comb begin
        flag_d = flag_q;
        if (soft_rst) begin
            flag_d = '0;
        end else begin
            if (clr) begin
                flag_d = '0;
            end
            flag_d = flag_d | set_vec;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= '0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign flag = flag_q;
endmodule : olc_flag_latch

/* File: hw/olc_pkg.sv */
// Purpose: Shared constants and types for the octal line control register bank
// Assumes: 100 MHz sys_clk, 8 channels, 8-bit host data
// Notes:   Offsets are byte addresses on the 8-bit host port
package olc_pkg;
    localparam int          NCH            = 8;
    localparam int          DW             = 8;
    localparam int          AW             = 5;

    // Register offsets
    localparam logic [4:0]  OFS_REV        = 5'h00;
    localparam logic [4:0]  OFS_ALB        = 5'h01;
    localparam logic [4:0]  OFS_RLB        = 5'h02;
    localparam logic [4:0]  OFS_ONES       = 5'h03;
    localparam logic [4:0]  OFS_CM_STAT    = 5'h04;
    localparam logic [4:0]  OFS_DF_STAT    = 5'h05;
    localparam logic [4:0]  OFS_CM_MASK    = 5'h06;
    localparam logic [4:0]  OFS_DF_MASK    = 5'h07;
    localparam logic [4:0]  OFS_CM_FLAG    = 5'h08;
    localparam logic [4:0]  OFS_DF_FLAG    = 5'h09;
    localparam logic [4:0]  OFS_SOFT_RST   = 5'h0a;
    localparam logic [4:0]  OFS_MON_CFG    = 5'h0b;
    localparam logic [4:0]  OFS_DLB        = 5'h0c;
    localparam logic [4:0]  OFS_CRIT       = 5'h0d;

    // Reset values
    localparam logic [7:0]  RST_CTRL       = 8'h00;
    localparam logic [7:0]  RST_SOFT_RST   = 8'hff;
    localparam logic [7:0]  RD_UNMAPPED    = 8'h00;

    // Monitor selector field
    localparam int          MON_SEL_LSB    = 0;
    localparam int          MON_SEL_W      = 4;
    localparam int          MON_DIR_BIT    = 3;
    localparam logic [2:0]  MON_CH_NONE    = 3'h0;

    // Soft reset timing
    localparam int          SOFT_RST_US    = 1;
    localparam int          CLK_MHZ        = 100;
    localparam int          SOFT_RST_CYC   = SOFT_RST_US * CLK_MHZ;
    localparam int          SR_CNT_W       = 8;

    typedef enum logic [1:0] {
        OLC_SR_IDLE = 2'b01,
        OLC_SR_BUSY = 2'b10
    } olc_sr_state_t;

    // Change of a status vector, gated by mask
    function automatic logic [NCH-1:0] olc_change_fn(
        input logic [NCH-1:0] prev,
        input logic [NCH-1:0] cur,
        input logic [NCH-1:0] mask
    );
        olc_change_fn = mask & (prev ^ cur);
    endfunction : olc_change_fn
endpackage : olc_pkg

/* File: hw/olc_regs.sv */
// Purpose: Primary host register bank of an eight-channel line interface
// Assumes: Host strobes and line status are synchronous to sys_clk
// Notes:   Read data is registered one cycle after the read strobe
//
// What this block does
// R1: Read-only 8-bit revision code at offset zero, fixed in silicon.
// R2: Analog loopback register, one enable bit per channel.
// R3: Remote loopback register, one enable bit per channel.
// R4: All-ones register makes a channel transmit continuous ones.
// R5: Read-only signal-loss status, one bit per channel.
// R6: Read-only driver-fault status, one bit per channel.
// R7: Signal-loss interrupt mask per channel, reset to zero.
// R8: Driver-fault interrupt mask per channel, reset to zero.
// R9: Signal-loss flags latch any masked change; cleared by status read.
// R10: Driver-fault flags latch any masked change; cleared by status read.
// R11: Soft-reset write keeps content, starts 1 us reset of all registers except signal-loss and driver-fault status, which hold.
// R12: Monitor selector: 0/8 none, 1-7 receivers, 9-15 transmitters.
// R13: Host keeps monitor configuration upper four bits at zero.
// R14: Digital loopback register, one enable bit per channel.
// R15: In E1, criterion bit zero selects ITU, one selects European.
// R16: In T1, the North American criterion always applies.
// R17: Bit n of each per-channel register belongs to channel n.
// R18: Interrupt output high while any interrupt flag is set.
`timescale 1ns/1ps
module olc_regs #(
    parameter logic [7:0] REV_CODE  = 8'h5a,  // Arbitrary value
    parameter int         RST_CYCLES = olc_pkg::SOFT_RST_CYC
) (
    input  wire logic                     sys_clk,
    input  wire logic                     rst_n,
    input  wire logic [olc_pkg::AW-1:0]   host_addr,
    input  wire logic [olc_pkg::DW-1:0]   host_wdata,
    input  wire logic                     host_wr,
    input  wire logic                     host_rd,
    output logic      [olc_pkg::DW-1:0]   host_rdata,
    input  wire logic [olc_pkg::NCH-1:0]  carrier_missing_in,
    input  wire logic [olc_pkg::NCH-1:0]  driver_fault_in,
    input  wire logic                     e1_mode,
    output logic      [olc_pkg::NCH-1:0]  analog_loopback_en,
    output logic      [olc_pkg::NCH-1:0]  remote_loopback_en,
    output logic      [olc_pkg::NCH-1:0]  digital_loopback_en,
    output logic      [olc_pkg::NCH-1:0]  all_ones_send_en,
    output logic      [olc_pkg::NCH-1:0]  crit_european,
    output logic                          crit_north_american,
    output logic                          mon_active,
    output logic                          mon_transmit,
    output logic      [2:0]               monitor_channel_select,
    output logic                          irq,
    output logic                          soft_rst_busy
);
    localparam int N = olc_pkg::NCH;

    // Control registers
    logic [N-1:0] analog_loopback_ctrl_q;
    logic [N-1:0] analog_loopback_ctrl_d;
    logic [N-1:0] remote_loopback_ctrl_q;
    logic [N-1:0] remote_loopback_ctrl_d;
    logic [N-1:0] all_ones_send_ctrl_q;
    logic [N-1:0] all_ones_send_ctrl_d;
    logic [N-1:0] carrier_missing_irq_mask_q;
    logic [N-1:0] carrier_missing_irq_mask_d;
    logic [N-1:0] driver_fault_irq_mask_q;
    logic [N-1:0] driver_fault_irq_mask_d;
    logic [7:0]   monitor_config_q;
    logic [7:0]   monitor_config_d;
    logic [N-1:0] digital_loopback_ctrl_q;
    logic [N-1:0] digital_loopback_ctrl_d;
    logic [N-1:0] alarm_criterion_select_q;
    logic [N-1:0] alarm_criterion_select_d;

    // Status and derived outputs
    logic [N-1:0] carrier_missing_status_q;
    logic [N-1:0] carrier_missing_status_d;
    logic [N-1:0] driver_fault_status_q;
    logic [N-1:0] driver_fault_status_d;
    logic [N-1:0] crit_european_q;
    logic [N-1:0] crit_european_d;
    logic         crit_north_american_q;
    logic         crit_north_american_d;
    logic         mon_active_q;
    logic         mon_active_d;
    logic         mon_transmit_q;
    logic         mon_transmit_d;
    logic [2:0]   mon_chan_q;
    logic [2:0]   mon_chan_d;
    logic         irq_q;
    logic         irq_d;
    logic [7:0]   rdata_q;
    logic [7:0]   rdata_d;

    // Internal strobes
    logic         wr_ok;
    logic         rd_ok;
    logic         soft_busy;
    logic         soft_start;
    logic         cm_rd_clr;
    logic         df_rd_clr;
    logic [N-1:0] cm_change;
    logic [N-1:0] df_change;
    logic [N-1:0] cm_flag;
    logic [N-1:0] df_flag;
    logic [3:0]   mon_sel;

    // R11: writes are ignored while the soft reset runs
    assign wr_ok      = host_wr && !soft_busy;
    assign rd_ok      = host_rd && !soft_busy;
    assign soft_start = wr_ok && (host_addr == olc_pkg::OFS_SOFT_RST);

    // R11: timed reset cycle
    olc_soft_reset #(
        .CYCLES (RST_CYCLES)
    ) u_soft_reset (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .start   (soft_start),
        .busy    (soft_busy)
    );

    // R9: reading signal-loss status clears its flags
    assign cm_rd_clr = rd_ok && (host_addr == olc_pkg::OFS_CM_STAT);
    // R10: reading driver-fault status clears its flags
    assign df_rd_clr = rd_ok && (host_addr == olc_pkg::OFS_DF_STAT);

    // R9: any masked change of signal loss
    assign cm_change = olc_pkg::olc_change_fn(carrier_missing_status_q,
                                              carrier_missing_in,
                                              carrier_missing_irq_mask_q);
    // R10: any masked change of driver fault
    assign df_change = olc_pkg::olc_change_fn(driver_fault_status_q,
                                              driver_fault_in,
                                              driver_fault_irq_mask_q);

    olc_flag_latch #(
        .NCH (N)
    ) u_cm_flags (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .soft_rst (soft_busy),
        .set_vec  (cm_change),
        .clr      (cm_rd_clr),
        .flag     (cm_flag)
    );

    olc_flag_latch #(
        .NCH (N)
    ) u_df_flags (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .soft_rst (soft_busy),
        .set_vec  (df_change),
        .clr      (df_rd_clr),
        .flag     (df_flag)
    );

    // Control register writes
    always_comb begin
        analog_loopback_ctrl_d     = analog_loopback_ctrl_q;
        remote_loopback_ctrl_d     = remote_loopback_ctrl_q;
        all_ones_send_ctrl_d       = all_ones_send_ctrl_q;
        carrier_missing_irq_mask_d = carrier_missing_irq_mask_q;
        driver_fault_irq_mask_d    = driver_fault_irq_mask_q;
        monitor_config_d           = monitor_config_q;
        digital_loopback_ctrl_d    = digital_loopback_ctrl_q;
        alarm_criterion_select_d   = alarm_criterion_select_q;
        if (soft_busy) begin
            // R11: defaults held during reset cycle
            analog_loopback_ctrl_d     = olc_pkg::RST_CTRL;
            remote_loopback_ctrl_d     = olc_pkg::RST_CTRL;
            all_ones_send_ctrl_d       = olc_pkg::RST_CTRL;
            carrier_missing_irq_mask_d = olc_pkg::RST_CTRL;
            driver_fault_irq_mask_d    = olc_pkg::RST_CTRL;
            monitor_config_d           = olc_pkg::RST_CTRL;
            digital_loopback_ctrl_d    = olc_pkg::RST_CTRL;
            alarm_criterion_select_d   = olc_pkg::RST_CTRL;
        end else if (wr_ok) begin
            // R17: bit n drives channel n
            case (host_addr)
                // R2: analog loopback bits
                olc_pkg::OFS_ALB:     analog_loopback_ctrl_d     = host_wdata;
                // R3: remote loopback bits
                olc_pkg::OFS_RLB:     remote_loopback_ctrl_d     = host_wdata;
                // R4: all-ones bits
                olc_pkg::OFS_ONES:    all_ones_send_ctrl_d       = host_wdata;
                // R7: signal-loss mask
                olc_pkg::OFS_CM_MASK: carrier_missing_irq_mask_d = host_wdata;
                // R8: driver-fault mask
                olc_pkg::OFS_DF_MASK: driver_fault_irq_mask_d    = host_wdata;
                olc_pkg::OFS_MON_CFG: monitor_config_d           = host_wdata;
                // R14: digital loopback bits
                olc_pkg::OFS_DLB:     digital_loopback_ctrl_d    = host_wdata;
                olc_pkg::OFS_CRIT:    alarm_criterion_select_d   = host_wdata;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            analog_loopback_ctrl_q     <= olc_pkg::RST_CTRL;
            remote_loopback_ctrl_q     <= olc_pkg::RST_CTRL;
            all_ones_send_ctrl_q       <= olc_pkg::RST_CTRL;
            carrier_missing_irq_mask_q <= olc_pkg::RST_CTRL;
            driver_fault_irq_mask_q    <= olc_pkg::RST_CTRL;
            monitor_config_q           <= olc_pkg::RST_CTRL;
            digital_loopback_ctrl_q    <= olc_pkg::RST_CTRL;
            alarm_criterion_select_q   <= olc_pkg::RST_CTRL;
        end else begin
            analog_loopback_ctrl_q     <= analog_loopback_ctrl_d;
            remote_loopback_ctrl_q     <= remote_loopback_ctrl_d;
            all_ones_send_ctrl_q       <= all_ones_send_ctrl_d;
            carrier_missing_irq_mask_q <= carrier_missing_irq_mask_d;
            driver_fault_irq_mask_q    <= driver_fault_irq_mask_d;
            monitor_config_q           <= monitor_config_d;
            digital_loopback_ctrl_q    <= digital_loopback_ctrl_d;
            alarm_criterion_select_q   <= alarm_criterion_select_d;
        end
    end

    // Status sampling and derived outputs
    assign mon_sel = monitor_config_d[olc_pkg::MON_SEL_LSB +: olc_pkg::MON_SEL_W];

    always_comb begin
        // R5: signal-loss status follows the receivers
        carrier_missing_status_d = carrier_missing_in;
        // R6: driver-fault status follows the drivers
        driver_fault_status_d    = driver_fault_in;
        if (soft_busy) begin
            carrier_missing_status_d = carrier_missing_status_q;
            driver_fault_status_d    = driver_fault_status_q;
        end
        // R15: E1 criterion per channel
        crit_european_d       = e1_mode ? alarm_criterion_select_d : '0;
        // R16: T1 ignores the select bits
        crit_north_american_d = !e1_mode;
        // R12: monitor selector decode
        mon_chan_d     = mon_sel[2:0];
        mon_active_d   = (mon_sel[2:0] != olc_pkg::MON_CH_NONE);
        mon_transmit_d = mon_active_d && mon_sel[olc_pkg::MON_DIR_BIT];
        // R18: interrupt while any flag set
        irq_d = (|cm_flag) || (|df_flag);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            carrier_missing_status_q <= '0;
            driver_fault_status_q    <= '0;
            crit_european_q          <= '0;
            crit_north_american_q    <= 1'b0;
            mon_chan_q               <= olc_pkg::MON_CH_NONE;
            mon_active_q             <= 1'b0;
            mon_transmit_q           <= 1'b0;
            irq_q                    <= 1'b0;
        end else begin
            carrier_missing_status_q <= carrier_missing_status_d;
            driver_fault_status_q    <= driver_fault_status_d;
            crit_european_q          <= crit_european_d;
            crit_north_american_q    <= crit_north_american_d;
            mon_chan_q               <= mon_chan_d;
            mon_active_q             <= mon_active_d;
            mon_transmit_q           <= mon_transmit_d;
            irq_q                    <= irq_d;
        end
    end

    // Read path
    always_comb begin
        rdata_d = rdata_q;
        if (rd_ok) begin
            case (host_addr)
                // R1: fixed revision code
                olc_pkg::OFS_REV:      rdata_d = REV_CODE;
                olc_pkg::OFS_ALB:      rdata_d = analog_loopback_ctrl_q;
                olc_pkg::OFS_RLB:      rdata_d = remote_loopback_ctrl_q;
                olc_pkg::OFS_ONES:     rdata_d = all_ones_send_ctrl_q;
                // R5: live signal-loss status
                olc_pkg::OFS_CM_STAT:  rdata_d = carrier_missing_status_q;
                // R6: live driver-fault status
                olc_pkg::OFS_DF_STAT:  rdata_d = driver_fault_status_q;
                olc_pkg::OFS_CM_MASK:  rdata_d = carrier_missing_irq_mask_q;
                olc_pkg::OFS_DF_MASK:  rdata_d = driver_fault_irq_mask_q;
                olc_pkg::OFS_CM_FLAG:  rdata_d = cm_flag;
                olc_pkg::OFS_DF_FLAG:  rdata_d = df_flag;
                // R11: content never changes
                olc_pkg::OFS_SOFT_RST: rdata_d = olc_pkg::RST_SOFT_RST;
                olc_pkg::OFS_MON_CFG:  rdata_d = monitor_config_q;
                olc_pkg::OFS_DLB:      rdata_d = digital_loopback_ctrl_q;
                olc_pkg::OFS_CRIT:     rdata_d = alarm_criterion_select_q;
                default:               rdata_d = olc_pkg::RD_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= olc_pkg::RD_UNMAPPED;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Outputs
    assign host_rdata             = rdata_q;
    assign analog_loopback_en     = analog_loopback_ctrl_q;
    assign remote_loopback_en     = remote_loopback_ctrl_q;
    assign digital_loopback_en    = digital_loopback_ctrl_q;
    assign all_ones_send_en       = all_ones_send_ctrl_q;
    assign crit_european          = crit_european_q;
    assign crit_north_american    = crit_north_american_q;
    assign mon_active             = mon_active_q;
    assign mon_transmit           = mon_transmit_q;
    assign monitor_channel_select = mon_chan_q;
    assign irq                    = irq_q;
    assign soft_rst_busy          = soft_busy;
endmodule : olc_regs

/* File: hw/olc_soft_reset.sv */
// Purpose: Timed soft reset pulse started by a host write
// Assumes: Start is a one-cycle pulse
// Notes:   A start while busy is ignored
`timescale 1ns/1ps
module olc_soft_reset #(
    parameter int CYCLES = olc_pkg::SOFT_RST_CYC
) (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic start,
    output logic      busy
);
    olc_pkg::olc_sr_state_t             state_q;
    olc_pkg::olc_sr_state_t             state_d;
    logic [olc_pkg::SR_CNT_W-1:0]       cnt_q;
    logic [olc_pkg::SR_CNT_W-1:0]       cnt_d;

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            olc_pkg::OLC_SR_IDLE: begin
                if (start) begin
                    state_d = olc_pkg::OLC_SR_BUSY;
                    cnt_d   = olc_pkg::SR_CNT_W'(CYCLES - 1);
                end
            end
            olc_pkg::OLC_SR_BUSY: begin
                if (cnt_q == '0) begin
                    state_d = olc_pkg::OLC_SR_IDLE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            default: begin
                state_d = olc_pkg::OLC_SR_IDLE;
                cnt_d   = '0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= olc_pkg::OLC_SR_IDLE;
            cnt_q   <= '0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    assign busy = (state_q == olc_pkg::OLC_SR_BUSY);
endmodule : olc_soft_reset

/* File: verif/olc_host_bfm.sv */
// Purpose: Host processor model on the register port
// Assumes: One-cycle strobes driven at the falling edge
// Notes:   Address is inverted while the bus idles, and write data too after a write
`timescale 1ns/1ps
module olc_host_bfm (
    input  wire logic       sys_clk,
    input  wire logic [7:0] host_rdata,
    output logic      [4:0] host_addr,
    output logic      [7:0] host_wdata,
    output logic            host_wr,
    output logic            host_rd
);
    initial begin
        host_addr  = 5'h1f;
        host_wdata = 8'h00;
        host_wr    = 1'b0;
        host_rd    = 1'b0;
    end
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        host_addr  = a;
        host_wdata = (a == 5'h0b) ? {4'h0, d[3:0]} : d;
        host_wr    = 1'b1;
        @(negedge sys_clk);
        host_wr    = 1'b0;
        host_addr  = ~host_addr;
        host_wdata = ~host_wdata;
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        host_addr = a;
        host_rd   = 1'b1;
        @(negedge sys_clk);
        d         = host_rdata;
        host_rd   = 1'b0;
        host_addr = ~host_addr;
    endtask : rd
endmodule : olc_host_bfm

/* File: verif/olc_regs_chk.sv */
// Purpose: Port-level checks of the register bank
// Assumes: One clock domain, active-low async reset
// Notes:   Attached by bind
`timescale 1ns/1ps
module olc_regs_chk #(
    parameter logic [7:0] REV_CODE   = 8'h5a,  // Arbitrary value
    parameter int         RST_CYCLES = 100
) (
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic [4:0] host_addr,
    input wire logic [7:0] host_wdata,
    input wire logic       host_wr,
    input wire logic       host_rd,
    input wire logic [7:0] host_rdata,
    input wire logic       e1_mode,
    input wire logic [7:0] analog_loopback_en,
    input wire logic [7:0] crit_european,
    input wire logic       crit_north_american,
    input wire logic       mon_active,
    input wire logic       mon_transmit,
    input wire logic [2:0] monitor_channel_select,
    input wire logic       irq,
    input wire logic       soft_rst_busy
);
    logic [7:0] wd_q;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    always_comb cnt_d = soft_rst_busy ? cnt_q + 8'h01 : 8'h00;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wd_q  <= 8'h00;
            cnt_q <= 8'h00;
        end else begin
            wd_q  <= host_wdata;
            cnt_q <= cnt_d;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence wr_at(logic [4:0] a);
        host_wr && !soft_rst_busy && host_addr == a;
    endsequence
    rev_read_a: assert property (
        host_rd && !soft_rst_busy && host_addr == 5'h00 |=> host_rdata == REV_CODE)
        else $error("revision readback wrong");
    alb_write_a: assert property (
        wr_at(5'h01) |=> analog_loopback_en == wd_q)
        else $error("analog loopback write lost");
    e1_crit_a: assert property (
        wr_at(5'h0d) ##0 e1_mode |=> crit_european == wd_q)
        else $error("criterion select wrong in E1");
    t1_crit_a: assert property (
        !e1_mode && !soft_rst_busy ##1 !soft_rst_busy |-> crit_north_american
        && crit_european == 8'h00) else $error("criterion wrong in T1");
    mon_decode_a: assert property (
        wr_at(5'h0b) |=> monitor_channel_select == wd_q[2:0] && mon_active ==
        (wd_q[2:0] != 3'h0) && mon_transmit == (wd_q[3] && wd_q[2:0] != 3'h0))
        else $error("monitor decode wrong");
    sr_start_a: assert property (
        wr_at(5'h0a) |-> ##[1:2] soft_rst_busy) else $error("soft reset not started");
    sr_length_a: assert property (
        $fell(soft_rst_busy) |-> cnt_q == 8'(RST_CYCLES)) else $error("soft reset length");
    irq_fall_a: assert property (
        $fell(irq) |-> $past(soft_rst_busy) || $past(soft_rst_busy, 2) || $past(host_rd, 2)
        && $past(host_addr, 2) inside {5'h04, 5'h05}) else $error("irq dropped uncleared");
endmodule : olc_regs_chk
bind olc_regs olc_regs_chk #(.REV_CODE(REV_CODE), .RST_CYCLES(RST_CYCLES)) chk_u (
    .sys_clk, .rst_n, .host_addr, .host_wdata, .host_wr, .host_rd, .host_rdata, .e1_mode,
    .analog_loopback_en, .crit_european, .crit_north_american, .mon_active, .mon_transmit,
    .monitor_channel_select, .irq, .soft_rst_busy);

/* File: verif/olc_regs_test.sv */
// Purpose: Self-checking bench for the register bank
// Assumes: Host model drives strobes at the falling edge
// Notes:   Soft reset shortened to RC cycles
`timescale 1ns/1ps
module olc_regs_test;
    localparam logic [7:0] REV = 8'h3c;  // Arbitrary value
    localparam int         RC  = 4;
    typedef struct packed {
        logic [4:0] a;
        logic [7:0] d;
        logic [7:0] q;
    } olc_row_t;
    logic       sys_clk;
    logic       rst_n;
    logic [4:0] host_addr;
    logic [7:0] host_wdata;
    logic       host_wr;
    logic       host_rd;
    logic [7:0] host_rdata;
    logic [7:0] carrier_missing_in;
    logic [7:0] driver_fault_in;
    logic       e1_mode;
    logic [7:0] analog_loopback_en;
    logic [7:0] remote_loopback_en;
    logic [7:0] digital_loopback_en;
    logic [7:0] all_ones_send_en;
    logic [7:0] crit_european;
    logic       crit_north_american;
    logic       mon_active;
    logic       mon_transmit;
    logic [2:0] monitor_channel_select;
    logic       irq;
    logic       soft_rst_busy;
    logic [7:0] rv;
    logic [7:0] g;
    int         fail_count;
    int         check_count;
    olc_row_t   rows [12] = '{'{5'h01, 8'ha5, 8'ha5}, '{5'h02, 8'h5a, 8'h5a},
        '{5'h03, 8'h81, 8'h81}, '{5'h0c, 8'h3c, 8'h3c}, '{5'h06, 8'hff, 8'hff},
        '{5'h07, 8'h01, 8'h01}, '{5'h0d, 8'h0f, 8'h0f}, '{5'h0b, 8'h09, 8'h09},
        '{5'h04, 8'hff, 8'h00}, '{5'h05, 8'hff, 8'h00}, '{5'h00, 8'hff, REV},
        '{5'h1f, 8'h77, 8'h00}};
    olc_regs #(.REV_CODE(REV), .RST_CYCLES(RC)) dut_u (
        .sys_clk, .rst_n, .host_addr, .host_wdata, .host_wr, .host_rd, .host_rdata,
        .carrier_missing_in, .driver_fault_in, .e1_mode, .analog_loopback_en,
        .remote_loopback_en, .digital_loopback_en, .all_ones_send_en, .crit_european,
        .crit_north_american, .mon_active, .mon_transmit, .monitor_channel_select, .irq,
        .soft_rst_busy);
    olc_host_bfm host_u (.sys_clk, .host_rdata, .host_addr, .host_wdata, .host_wr, .host_rd);
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk8
    task automatic chk1(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk1
    task automatic rdc(input logic [4:0] a, input logic [7:0] e);
        host_u.rd(a, rv);
        chk8(rv, e);
    endtask : rdc
    task automatic flag_case(input logic [4:0] so, input logic [7:0] ef, input logic [7:0] es);
        repeat (3) @(negedge sys_clk);
        rdc(so + 5'h04, ef);
        chk1(irq, 1'b1);
        rdc(so, es);
        rdc(so + 5'h04, 8'h00);
        chk1(irq, 1'b0);
    endtask : flag_case
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        #100us;
        fail_count++;
        $display("[ERR] %0t watchdog expired", $time);
        close_out();
    end
    initial begin
        fail_count         = 0;
        check_count        = 0;
        rst_n              = 1'b0;
        carrier_missing_in = 8'h00;
        driver_fault_in    = 8'h00;
        e1_mode            = 1'b1;
        repeat (5) @(negedge sys_clk);
        rst_n = 1'b1;
        foreach (rows[i]) begin
            host_u.wr(rows[i].a, rows[i].d);
            case (rows[i].a)
                5'h01: g = analog_loopback_en;
                5'h02: g = remote_loopback_en;
                5'h03: g = all_ones_send_en;
                default: g = digital_loopback_en;
            endcase
            if (rows[i].a inside {5'h01, 5'h02, 5'h03, 5'h0c}) begin
                chk8(g, rows[i].q);
            end
            rdc(rows[i].a, rows[i].q);
        end
        $display("table test done");
        host_u.wr(5'h0a, 8'h00);
        @(negedge sys_clk);
        host_u.wr(5'h01, 8'hff);
        chk1(soft_rst_busy, 1'b1);
        @(negedge sys_clk);
        chk1(soft_rst_busy, 1'b0);
        for (int a = 0; a < 14; a++) begin
            rdc(5'(a), (a == 0) ? REV : ((a == 10) ? 8'hff : 8'h00));
        end
        chk8(analog_loopback_en | remote_loopback_en | digital_loopback_en, 8'h00);
        $display("soft reset test done");
        host_u.wr(5'h06, 8'h05);
        host_u.wr(5'h07, 8'h80);
        carrier_missing_in = 8'h07;
        flag_case(5'h04, 8'h05, 8'h07);
        carrier_missing_in = 8'h00;
        flag_case(5'h04, 8'h05, 8'h00);
        driver_fault_in = 8'h81;
        flag_case(5'h05, 8'h80, 8'h81);
        $display("flag test done");
        host_u.wr(5'h0d, 8'ha5);
        chk8(crit_european, 8'ha5);
        chk1(crit_north_american, 1'b0);
        e1_mode = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk8(crit_european, 8'h00);
        chk1(crit_north_american, 1'b1);
        $display("criterion test done");
        for (int c = 0; c < 16; c++) begin
            host_u.wr(5'h0b, 8'(c));
            chk1(mon_active, c % 8 != 0);
            chk1(mon_transmit, c > 8);
            chk8({5'h00, monitor_channel_select}, 8'(c % 8));
        end
        $display("monitor test done");
        close_out();
    end
endmodule : olc_regs_test
